// ==== ialu_pkg.sv ====
// Shared constants, register map and types of the integer ALU block
package ialu_pkg;
    // AXI4-Lite geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] OFF_OPA = 8'h00;
    localparam logic [7:0] OFF_OPB = 8'h04;
    localparam logic [7:0] OFF_SHAMT = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0C;
    localparam logic [7:0] OFF_IMM = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    // Writable bit masks
    localparam logic [31:0] CTRL_MASK = 32'h0003_FFFF;
    localparam logic [31:0] IMM_MASK = 32'h0000_0FFF;
    localparam logic [31:0] FLAGS_MASK = 32'h0000_000F;
    // Reset values and the counter step
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    // Response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Datapath constants
    localparam logic [7:0] SHIFT_NONE = 8'h00;
    localparam logic [5:0] LZC_ALL_ZERO = 6'h20;
    localparam int IMM_W = 12;
    localparam int SHAMT_W = 8;

    // Operation codes
    typedef enum logic [3:0] {
        OP_ADD, OP_CARRY_SUM, OP_DIFFERENCE, OP_BORROW_DIFFERENCE,
        OP_REVERSED_DIFFERENCE, OP_AND, OP_BITWISE_OR, OP_EXCLUSIVE_OR,
        OP_BIT_CLEAR, OP_OR_INVERTED, OP_ARITH_RIGHT_SHIFT,
        OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_RIGHT,
        OP_EXTENDED_ROTATE, OP_LEADING_ZERO_COUNT
    } ialu_op_e;

    // Control word layout, bit 31 first
    typedef struct packed {
        logic [13:0] rsvd;
        logic sh_c_val;
        logic sh_c_en;
        logic pc_dest;
        logic opa_pc;
        logic [5:0] shift_n;
        logic shift_imm;
        logic use_imm;
        logic cond_pass;
        logic set_flags;
        ialu_op_e op;
    } ialu_ctrl_s;

    // Condition flags, negative in bit 3
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } ialu_flags_s;
endpackage

// ==== ialu_core.sv ====
// Integer add/subtract, logic, shift and leading-zero datapath with AXI4-Lite registers
//
// What this block does
// [RULE_01] Add sums first operand and operand/immediate
// [RULE_02] Carry sum adds carry flag as carry-in
// [RULE_03] Difference subtracts operand or immediate
// [RULE_04] Borrow difference subtracts one more without carry
// [RULE_05] Reversed difference swaps operand order
// [RULE_06] Arithmetic with flag suffix sets NZCV
// [RULE_07] Program counter operand low bits forced zero; the code aligns it for arithmetic only, logic ops take opa unaligned
// [RULE_08] PC-destination add clears result bit zero
// [RULE_09] Stack pointer destination limited by issuer
// [RULE_10] PC first operand limited by issuer
// [RULE_11] AND, OR, exclusive OR are bitwise
// [RULE_12] Bit clear ANDs with inverted operand
// [RULE_13] Or inverted ORs with inverted operand
// [RULE_14] Logic flags: NZ, optional C, V kept
// [RULE_15] Register shift uses low byte only
// [RULE_16] Immediate shift ranges supported in full
// [RULE_17] Shifts write destination, source untouched
// [RULE_18] Shift flags: NZ, C last out
// [RULE_19] Leading zero count from bit 31
// [RULE_20] Leading zero count keeps all flags
// [RULE_21] Extended rotate inserts carry at top
// [RULE_22] Failed condition suppresses write and flags
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module ialu_core (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [ialu_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [ialu_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [ialu_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [ialu_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Result towards register file and flags
    output logic rf_we,
    output logic [31:0] rf_wdata,
    output logic pc_branch,
    output ialu_pkg::ialu_flags_s flags
);

    // True when an address selects a given register word
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // Byte-lane merge of a write under a writable mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~m) | (nw & m);
    endfunction

    // 32-bit adder returning {overflow, carry, sum}
    function automatic logic [33:0] add32(input logic [31:0] a, input logic [31:0] b,
                                          input logic ci);
        logic [32:0] s;
        logic v;
        s = {1'b0, a} + {1'b0, b} + {32'h0000_0000, ci};
        v = (a[31] == b[31]) && (s[31] != a[31]);
        return {v, s};
    endfunction

    // Shifter returning {carry out, result}; zero amount keeps carry except on extended rotate
    function automatic logic [32:0] shift32(input ialu_pkg::ialu_op_e op,
                                            input logic [31:0] v, input logic [7:0] amt,
                                            input logic ci);
        logic [63:0] t;
        logic [32:0] o;
        t = 64'h0;
        o = {ci, v};
        case (op)
            ialu_pkg::OP_LOGICAL_LEFT_SHIFT: begin
                t = {32'h0000_0000, v} << amt;
                o = {t[32], t[31:0]};
            end
            ialu_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
                t = {v, 32'h0000_0000} >> amt;
                o = {t[31], t[63:32]};
            end
            ialu_pkg::OP_ARITH_RIGHT_SHIFT: begin
                t = $signed({v, 32'h0000_0000}) >>> amt;
                o = {t[31], t[63:32]};
            end
            ialu_pkg::OP_ROTATE_RIGHT: begin
                // Only the amount modulo 32 matters for the rotated value; a zero amount keeps carry
                t = {v, v} >> amt[4:0];
                o = {t[31], t[31:0]};
            end
            // [RULE_21] carry into top
            ialu_pkg::OP_EXTENDED_ROTATE: o = {v[0], ci, v[31:1]};
            default: o = {ci, v};
        endcase
        // [RULE_18] zero amount keeps carry
        if (amt == ialu_pkg::SHIFT_NONE && op != ialu_pkg::OP_EXTENDED_ROTATE) o[32] = ci;
        return o;
    endfunction

    // Count of zero bits above the highest one
    function automatic logic [5:0] lzc32(input logic [31:0] v);
        logic [5:0] n;
        logic hit;
        n = 6'h00;
        hit = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) hit = 1'b1;
            else if (!hit) n = n + 6'h01;
        end
        return n;
    endfunction

    // Software-visible registers and the internal launch flag
    logic [31:0] opa;                  // First operand register
    logic [31:0] opb;                  // Flexible second operand / source register
    logic [31:0] shamt;                // Shift amount register
    logic [31:0] imm;                  // Twelve-bit immediate
    ialu_pkg::ialu_ctrl_s ctrl;        // Operation control
    logic [15:0] op_count;             // Executed operations
    logic exec_pend;                   // Control word just written

    // Bus channel state
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Write channel handshakes and commit
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire do_write = aw_full && w_full && !bvalid;
    wire next_aw_full = aw_take || (aw_full && !do_write);
    wire next_w_full = w_take || (w_full && !do_write);
    wire next_bvalid = do_write || (bvalid && !bready);

    // Read channel handshake
    wire ar_take = arvalid && arready;
    wire next_rvalid = ar_take || (rvalid && !rready);

    // Write address decode
    wire wr_opa = do_write && reg_hit(aw_addr, ialu_pkg::OFF_OPA);
    wire wr_opb = do_write && reg_hit(aw_addr, ialu_pkg::OFF_OPB);
    wire wr_shamt = do_write && reg_hit(aw_addr, ialu_pkg::OFF_SHAMT);
    wire wr_ctrl = do_write && reg_hit(aw_addr, ialu_pkg::OFF_CTRL);
    wire wr_imm = do_write && reg_hit(aw_addr, ialu_pkg::OFF_IMM);
    wire wr_flags = do_write && reg_hit(aw_addr, ialu_pkg::OFF_FLAGS);
    // Read-only words accept writes silently; beyond the map is an error
    wire wr_ro = reg_hit(aw_addr, ialu_pkg::OFF_RESULT) ||
                 reg_hit(aw_addr, ialu_pkg::OFF_STATUS);
    wire wr_ok = wr_opa || wr_opb || wr_shamt || wr_ctrl || wr_imm || wr_flags || wr_ro;

    // Read address decode and data select
    wire rd_map = araddr < 8'h20;
    wire [31:0] rd_word =
        reg_hit(araddr, ialu_pkg::OFF_OPA) ? opa :
        reg_hit(araddr, ialu_pkg::OFF_OPB) ? opb :
        reg_hit(araddr, ialu_pkg::OFF_SHAMT) ? shamt :
        reg_hit(araddr, ialu_pkg::OFF_CTRL) ? (32'(ctrl) & ialu_pkg::CTRL_MASK) :
        reg_hit(araddr, ialu_pkg::OFF_IMM) ? imm :
        reg_hit(araddr, ialu_pkg::OFF_FLAGS) ? {28'h000_0000, flags} :
        reg_hit(araddr, ialu_pkg::OFF_RESULT) ? rf_wdata :
        reg_hit(araddr, ialu_pkg::OFF_STATUS) ? {16'h0000, op_count} :
        ialu_pkg::WORD_RST;

    // Operation class decode
    wire is_arith = ctrl.op <= ialu_pkg::OP_REVERSED_DIFFERENCE;
    wire is_logic = ctrl.op >= ialu_pkg::OP_AND && ctrl.op <= ialu_pkg::OP_OR_INVERTED;
    wire is_shift = ctrl.op >= ialu_pkg::OP_ARITH_RIGHT_SHIFT &&
                    ctrl.op <= ialu_pkg::OP_EXTENDED_ROTATE;
    wire is_lzc = ctrl.op == ialu_pkg::OP_LEADING_ZERO_COUNT;
    wire is_xrot = ctrl.op == ialu_pkg::OP_EXTENDED_ROTATE;

    // [RULE_07] word-aligned pc base
    wire [31:0] opa_eff = ctrl.opa_pc ? {opa[31:2], 2'b00} : opa;
    // [RULE_01] immediate or operand
    wire [31:0] opb_eff = ctrl.use_imm ? {20'h0_0000, imm[ialu_pkg::IMM_W-1:0]} : opb;

    // Adder inputs per operation: subtraction is A + ~B + carry-in
    wire sub_b = ctrl.op == ialu_pkg::OP_DIFFERENCE ||
                 ctrl.op == ialu_pkg::OP_BORROW_DIFFERENCE;
    wire rev = ctrl.op == ialu_pkg::OP_REVERSED_DIFFERENCE;
    // [RULE_05] swapped order
    wire [31:0] add_a = rev ? ~opa_eff : opa_eff;
    // [RULE_03] inverted subtrahend
    wire [31:0] add_b = sub_b ? ~opb_eff : opb_eff;
    // [RULE_02] [RULE_04] carry flag feeds in
    wire add_ci = (ctrl.op == ialu_pkg::OP_CARRY_SUM ||
                   ctrl.op == ialu_pkg::OP_BORROW_DIFFERENCE) ? flags.c :
                  (ctrl.op == ialu_pkg::OP_DIFFERENCE || rev);
    wire [33:0] add_out = add32(add_a, add_b, add_ci);

    // [RULE_11] [RULE_12] [RULE_13] bitwise results
    wire [31:0] logic_out =
        ctrl.op == ialu_pkg::OP_AND ? (opa & opb) :
        ctrl.op == ialu_pkg::OP_BITWISE_OR ? (opa | opb) :
        ctrl.op == ialu_pkg::OP_EXCLUSIVE_OR ? (opa ^ opb) :
        ctrl.op == ialu_pkg::OP_BIT_CLEAR ? (opa & ~opb) :
        (opa | ~opb);

    // [RULE_15] [RULE_16] amount source
    wire [7:0] sh_amt = ctrl.shift_imm ? {2'b00, ctrl.shift_n} :
                        shamt[ialu_pkg::SHAMT_W-1:0];
    // [RULE_17] source register only read
    wire [32:0] sh_out = shift32(ctrl.op, opb, sh_amt, flags.c);
    // [RULE_19] leading zero count
    wire [31:0] lzc_out = {26'h0, lzc32(opb)};

    // Result select
    wire [31:0] res = is_arith ? add_out[31:0] :
                      is_logic ? logic_out :
                      is_shift ? sh_out[31:0] : lzc_out;

    // Next flags per class
    wire res_zero = res == ialu_pkg::WORD_RST;
    // [RULE_14] optional shifter carry
    wire logic_c = ctrl.sh_c_en ? ctrl.sh_c_val : flags.c;
    wire next_c = is_arith ? add_out[32] : is_logic ? logic_c : sh_out[32];
    // [RULE_06] [RULE_14] [RULE_18] overflow only from arithmetic
    wire next_v = is_arith ? add_out[33] : flags.v;
    wire ialu_pkg::ialu_flags_s next_flags = '{n: res[31], z: res_zero, c: next_c, v: next_v};

    // [RULE_22] failed condition suppresses all
    wire go = exec_pend && ctrl.cond_pass;
    // [RULE_20] leading zero count never flags
    wire flag_upd = go && ctrl.set_flags && !is_lzc;
    // [RULE_08] branch target bit zero cleared
    wire [31:0] next_wdata = ctrl.pc_dest ? {res[31:1], 1'b0} : res;
    wire next_branch = go && ctrl.pc_dest && ctrl.op == ialu_pkg::OP_ADD;
    wire [31:0] sw_flags = merge({28'h000_0000, flags}, w_data, w_strb, ialu_pkg::FLAGS_MASK);

    // Write channel: hold address and data until both are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= ialu_pkg::RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= ialu_pkg::WORD_RST;
            w_strb <= 4'h0;
        end else if (ce) begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= !next_aw_full;
            wready <= !next_w_full;
            bvalid <= next_bvalid;
            if (aw_take) aw_addr <= awaddr;
            if (w_take) begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) bresp <= wr_ok ? ialu_pkg::RESP_OKAY : ialu_pkg::RESP_SLVERR;
        end
    end

    // Read channel: one registered answer per request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= ialu_pkg::WORD_RST;
            rresp <= ialu_pkg::RESP_OKAY;
        end else if (ce) begin
            arready <= !next_rvalid;
            rvalid <= next_rvalid;
            if (ar_take) begin
                rdata <= rd_map ? rd_word : ialu_pkg::WORD_RST;
                rresp <= rd_map ? ialu_pkg::RESP_OKAY : ialu_pkg::RESP_SLVERR;
            end
        end
    end

    // Operand and control registers; a control write launches one operation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opa <= ialu_pkg::WORD_RST;
            opb <= ialu_pkg::WORD_RST;
            shamt <= ialu_pkg::WORD_RST;
            imm <= ialu_pkg::WORD_RST;
            ctrl <= ialu_pkg::ialu_ctrl_s'(ialu_pkg::WORD_RST);
            exec_pend <= 1'b0;
        end else if (ce) begin
            exec_pend <= wr_ctrl;
            if (wr_opa) opa <= merge(opa, w_data, w_strb, '1);
            if (wr_opb) opb <= merge(opb, w_data, w_strb, '1);
            if (wr_shamt) shamt <= merge(shamt, w_data, w_strb, '1);
            if (wr_imm) imm <= merge(imm, w_data, w_strb, ialu_pkg::IMM_MASK);
            if (wr_ctrl) begin
                ctrl <= ialu_pkg::ialu_ctrl_s'(merge(32'(ctrl), w_data, w_strb,
                                                     ialu_pkg::CTRL_MASK));
            end
        end
    end

    // Result, flags and counters; a flag-setting operation beats a software flag write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rf_we <= 1'b0;
            rf_wdata <= ialu_pkg::WORD_RST;
            pc_branch <= 1'b0;
            flags <= ialu_pkg::ialu_flags_s'(4'h0);
            op_count <= ialu_pkg::COUNT_RST;
        end else if (ce) begin
            rf_we <= go;
            pc_branch <= next_branch;
            if (go) begin
                rf_wdata <= next_wdata;
                op_count <= op_count + ialu_pkg::COUNT_ONE;
            end
            if (flag_upd) flags <= next_flags;
            else if (wr_flags) flags <= sw_flags[3:0];
        end
    end

    // Checks on the datapath
    property p_add_sum; // [RULE_01]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && ctrl.op == ialu_pkg::OP_ADD && !ctrl.opa_pc && !ctrl.pc_dest)
        |=> rf_we && rf_wdata == $past(opa) + $past(opb_eff);
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("add result wrong"); // [RULE_01]
    property p_pc_align; // [RULE_07]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && ctrl.op == ialu_pkg::OP_ADD && ctrl.opa_pc && ctrl.use_imm)
        |=> rf_wdata == {$past(opa[31:2]), 2'b00} + {20'h0_0000, $past(imm[11:0])};
    endproperty
    a_pc_align: assert property (p_pc_align) else $error("pc base not aligned"); // [RULE_07]
    property p_diff; // [RULE_03]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && ctrl.op == ialu_pkg::OP_DIFFERENCE)
        |=> rf_wdata == $past(opa_eff) - $past(opb_eff);
    endproperty
    a_diff: assert property (p_diff) else $error("difference wrong"); // [RULE_03]
    property p_rev; // [RULE_05]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && rev) |=> rf_wdata == $past(opb_eff) - $past(opa_eff);
    endproperty
    a_rev: assert property (p_rev) else $error("reversed difference wrong"); // [RULE_05]
    property p_cond_fail; // [RULE_22]
        @(posedge aclk) disable iff (!aresetn)
        (ce && exec_pend && !ctrl.cond_pass) |=> !rf_we && !pc_branch && $stable(rf_wdata);
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("failed op wrote"); // [RULE_22]
    property p_lzc_flags; // [RULE_20]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && is_lzc) |=> flags == $past(flags);
    endproperty
    a_lzc_flags: assert property (p_lzc_flags) else $error("count changed flags"); // [RULE_20]
    property p_lzc_zero; // [RULE_19]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && is_lzc && opb == ialu_pkg::WORD_RST)
        |=> rf_wdata == {26'h0, ialu_pkg::LZC_ALL_ZERO};
    endproperty
    a_lzc_zero: assert property (p_lzc_zero) else $error("zero input count wrong"); // [RULE_19]
    property p_logic_v; // [RULE_14]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && ctrl.set_flags && is_logic)
        |=> flags.v == $past(flags.v) && flags.z == (rf_wdata == ialu_pkg::WORD_RST);
    endproperty
    a_logic_v: assert property (p_logic_v) else $error("logic flags wrong"); // [RULE_14]
    property p_shift_c; // [RULE_18]
        @(posedge aclk) disable iff (!aresetn)
        (ce && go && ctrl.set_flags && is_shift && !is_xrot && sh_amt == ialu_pkg::SHIFT_NONE)
        |=> flags.c == $past(flags.c) && rf_wdata == $past(opb);
    endproperty
    a_shift_c: assert property (p_shift_c) else $error("zero shift moved carry"); // [RULE_18]
    property p_branch; // [RULE_08]
        @(posedge aclk) disable iff (!aresetn)
        pc_branch |-> rf_we && !rf_wdata[0];
    endproperty
    a_branch: assert property (p_branch) else $error("branch bit zero set"); // [RULE_08]

endmodule // ialu_core

// ==== ialu_rf_model.sv ====
// Register-file side model that records what the ALU hands over
`timescale 1ns/1ns
module ialu_rf_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Result side of the ALU
    input wire logic rf_we,
    input wire logic [31:0] rf_wdata,
    input wire logic pc_branch,
    // Observed history
    output logic [15:0] wr_count,
    output logic [15:0] br_count,
    output logic [31:0] last_value
);
    // Count writes and branches; the value is taken with its strobe, never later
    // no stack pointer path
    // The issuer here never names the stack pointer, so no such write can arrive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_count <= 16'h0000;
            br_count <= 16'h0000;
            last_value <= 32'h00000000;
        end else begin
            // Only a strobed value lands in the file
            if (rf_we) begin
                wr_count <= wr_count + 16'h0001;
                last_value <= rf_wdata;
            end
            // Branches are counted apart from writes
            if (pc_branch) begin
                br_count <= br_count + 16'h0001;
            end
        end
    end
endmodule // ialu_rf_model

// ==== test_integer_alu_shift_clz.sv ====
// Self-checking bench for the integer ALU driven over its register bus
`timescale 1ns/1ns
module test_integer_alu_shift_clz;
    // Table row: control, operands, shift/immediate, flags in, then expected outputs
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] s;
        logic [3:0] fin;
        logic [31:0] res;
        logic [3:0] fout;
    } ialu_row_s;
    localparam int NROWS = 30;
    // Inputs, all given a value at time zero
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    // Outputs of the core and of the model
    logic awready, wready, bvalid, arready, rvalid, rf_we, pc_branch;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rf_wdata, last_value;
    logic [15:0] wr_count, br_count;
    ialu_pkg::ialu_flags_s flags;
    int bad_count = 0;
    int check_count = 0;
    // Ordinary cases; flags nibble is n,z,c,v
    ialu_row_s rows [NROWS] = '{
        '{32'h70, 32'h1, 32'h0, 32'hFFF, 4'hF, 32'h1000, 4'h0},
        '{32'h30, 32'h7FFFFFFF, 32'h1, 32'h0, 4'h0, 32'h80000000, 4'h9},
        '{32'h30, 32'hFFFFFFFF, 32'h1, 32'h0, 4'h0, 32'h0, 4'h6},
        '{32'h31, 32'h5, 32'h6, 32'h0, 4'h2, 32'hC, 4'h0},
        '{32'h72, 32'h100, 32'h0, 32'h100, 4'h0, 32'h0, 4'h6},
        '{32'h32, 32'h1, 32'h2, 32'h0, 4'h0, 32'hFFFFFFFF, 4'h8},
        '{32'h33, 32'hA, 32'h3, 32'h0, 4'h0, 32'h6, 4'h2},
        '{32'h33, 32'hA, 32'h3, 32'h0, 4'h2, 32'h7, 4'h2},
        '{32'h34, 32'h3, 32'hA, 32'h0, 4'h0, 32'h7, 4'h2},
        '{32'h20, 32'h1, 32'h1, 32'h0, 4'hF, 32'h2, 4'hF},
        '{32'h4060, 32'h1003, 32'h0, 32'h4, 4'h0, 32'h1004, 4'h0},
        '{32'hC020, 32'h1002, 32'h7, 32'h0, 4'h0, 32'h1006, 4'h0},
        '{32'h35, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 4'h3, 32'hF000F000, 4'hB},
        '{32'h36, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 4'h0, 32'hFFF0FFF0, 4'h8},
        '{32'h37, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 4'h1, 32'h0FF00FF0, 4'h1},
        '{32'h38, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 4'h0, 32'h00F000F0, 4'h0},
        '{32'h30039, 32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 4'h0, 32'hF0FFF0FF, 4'hA},
        '{32'h10035, 32'hF, 32'hF0, 32'h0, 4'h2, 32'h0, 4'h4},
        '{32'h3A, 32'h0, 32'h80000000, 32'h104, 4'h2, 32'hF8000000, 4'h8},
        '{32'h20BA, 32'h0, 32'h80000000, 32'h0, 4'h0, 32'hFFFFFFFF, 4'hA},
        '{32'h1FBB, 32'h0, 32'h3, 32'h0, 4'h0, 32'h80000000, 4'hA},
        '{32'h3B, 32'h0, 32'h5, 32'h100, 4'h2, 32'h5, 4'h2},
        '{32'h20BC, 32'h0, 32'h80000001, 32'h0, 4'h0, 32'h0, 4'h6},
        '{32'h3C, 32'h0, 32'hFFFFFFFF, 32'hFF, 4'h2, 32'h0, 4'h4},
        '{32'h1BD, 32'h0, 32'h1, 32'h0, 4'h0, 32'h80000000, 4'hA},
        '{32'h1FBD, 32'h0, 32'h1, 32'h0, 4'h2, 32'h2, 4'h0},
        '{32'h3E, 32'h0, 32'h3, 32'h0, 4'h2, 32'h80000001, 4'hA},
        '{32'h3F, 32'h0, 32'h0, 32'h0, 4'hF, 32'h20, 4'hF},
        '{32'h3F, 32'h0, 32'h80000000, 32'h0, 4'h0, 32'h0, 4'h0},
        '{32'h3F, 32'h0, 32'h00010000, 32'h0, 4'h0, 32'hF, 4'h0}
    };
    // Core under test and the register-file model beside it
    ialu_core ialu_core_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rf_we(rf_we), .rf_wdata(rf_wdata), .pc_branch(pc_branch),
        .flags(flags));
    ialu_rf_model ialu_rf_model_i (.aclk(aclk), .aresetn(aresetn), .rf_we(rf_we),
        .rf_wdata(rf_wdata), .pc_branch(pc_branch), .wr_count(wr_count),
        .br_count(br_count), .last_value(last_value));
    // 125 MHz clock
    always #4 aclk = ~aclk;
    // Compare and count; case inequality so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // A bus wait ran out
    task automatic hang();
        bad_count++;
        $display("BAD %0t bus wait ran out", $time);
        summarize();
    endtask
    // One write; an idle edge first so bready is never set twice in one step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (bvalid !== 1'b1) hang();
        r = bresp;
        bready <= 1'b0;
    endtask
    // One read, same discipline
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (rvalid !== 1'b1) hang();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Load operands, launch, then check result, flags and the untouched source
    task automatic run_row(input ialu_row_s w);
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(ialu_pkg::OFF_FLAGS, {28'h0, w.fin}, r);
        axi_wr(ialu_pkg::OFF_OPA, w.a, r);
        axi_wr(ialu_pkg::OFF_OPB, w.b, r);
        axi_wr(ialu_pkg::OFF_SHAMT, w.s, r);
        axi_wr(ialu_pkg::OFF_IMM, w.s, r);
        axi_wr(ialu_pkg::OFF_CTRL, w.ctrl, r);
        axi_rd(ialu_pkg::OFF_RESULT, d, r);
        chk(d, w.res);
        chk({28'h0, flags}, {28'h0, w.fout});
        axi_rd(ialu_pkg::OFF_OPB, d, r);
        chk(d, w.b);
    endtask
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state, then an unmapped address both ways
        axi_rd(ialu_pkg::OFF_STATUS, d, r);
        chk(d, 32'h0);
        axi_wr(8'h20, 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, ialu_pkg::RESP_SLVERR});
        axi_rd(8'h20, d, r);
        chk({r, d[29:0]}, {ialu_pkg::RESP_SLVERR, 30'h0});
        for (int i = 0; i < NROWS; i++) run_row(rows[i]);
        chk({16'h0, br_count}, 32'h1);
        chk(last_value, 32'hF);
        // A failed condition leaves result, flags and write count alone
        run_row('{32'h10, 32'h1, 32'h1, 32'h0, 4'hF, 32'hF, 4'hF});
        chk({16'h0, wr_count}, 32'(NROWS));
        axi_rd(ialu_pkg::OFF_STATUS, d, r);
        chk(d, 32'(NROWS));
        // A reset in mid-run clears count, result and flags
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ialu_pkg::OFF_STATUS, d, r);
        chk(d, 32'h0);
        chk(rf_wdata, 32'h0);
        chk({28'h0, flags}, 32'h0);
        summarize();
    end
endmodule // test_integer_alu_shift_clz
